// [rtl/arcp_port.sv]
// Control logic of the isolated analog remote-control port.
// Assumes converter codes and alarm levels come from logic on clk_sys,
// and the three digital control pins are asynchronous.
`timescale 1ns/1ps
`include "arcp_map.svh"

module arcp_port #(
    parameter int W       = `ARCP_CODE_W,
    parameter int DEB_CYC = `ARCP_DEBOUNCE_CYC,
    parameter int ACK_CYC = `ARCP_ACK_LOW_CYC
) (
    input  wire logic          clk_sys,          // system clock
    input  wire logic          resetn,           // async reset, low
    input  wire logic          ce,               // clock enable
    input  wire logic          psel,             // APB select
    input  wire logic          penable,          // APB enable
    input  wire logic          pwrite,           // APB direction
    input  wire logic [7:0]    paddr,            // APB byte address
    input  wire logic [31:0]   pwdata,           // APB write data
    output logic      [31:0]   prdata,           // APB read data
    output logic               pready,           // APB ready
    output logic               pslverr,          // APB error
    input  wire logic [W-1:0]  voltage_setpoint_in,    // pin code
    input  wire logic [W-1:0]  current_setpoint_in,    // pin code
    input  wire logic [W-1:0]  power_setpoint_in,      // pin code
    input  wire logic [W-1:0]  resistance_setpoint_in, // pin code
    input  wire logic          remote_select_n_in,     // pin, low=remote
    input  wire logic          resistance_mode_in,     // pin, high=on
    input  wire logic          output_standby_in,      // pin, low=off
    input  wire logic [W-1:0]  actual_voltage,   // measured, of nominal
    input  wire logic [W-1:0]  actual_current,   // measured, of nominal
    input  wire logic          heat_alarm,       // alarm level
    input  wire logic          power_fail_alarm, // alarm level
    input  wire logic          excess_voltage_alarm, // alarm level
    input  wire logic          excess_current_alarm, // alarm level
    input  wire logic [1:0]    regulation_mode,  // arcp_reg_mode_t
    output logic [4*W-1:0]     applied_setpoint, // to output stage
    output logic               resistance_enable, // R mode applied
    output logic [4*W-1:0]     display_setpoint, // to the display
    output logic [W-1:0]       ovp_threshold,    // protection level
    output logic [W-1:0]       voltage_monitor_out, // monitor DAC code
    output logic [W-1:0]       current_monitor_out, // monitor DAC code
    output logic [W-1:0]       reference_out,    // reference DAC code
    output logic               dc_output_on,     // output stage enable
    output logic               heat_or_supply_fail_out, // status pin
    output logic               excess_voltage_alarm_out, // status pin
    output logic               const_voltage_status_out, // status pin
    output logic               alarm_ack_pulse   // acknowledge event
);
    localparam int AW = $clog2(ACK_CYC + 1);

    logic [1:0]       ctrl;
    logic [W-1:0]     panel [4];
    logic [W-1:0]     limit [4];
    logic [W-1:0]     port_value [4];
    logic [W-1:0]     port_code [4];
    logic             remote_n;
    logic             rmode;
    logic             standby;
    logic             remote;
    logic             range10;
    logic             latched;
    logic             ack_seen;
    logic [AW-1:0]    low_count;
    logic             any_alarm;
    logic             sw_ack;
    logic             wr_en;
    logic             rd_setup;
    logic [31:0]      next_rdata;
    logic             next_err;
    arcp_pkg::arcp_sb_state_t sb_state;

    generate
        if (W < 8 || DEB_CYC < 1 || ACK_CYC < 2)
        begin : g_bad
            $error("arcp_port: unsupported parameter values");
        end
    endgenerate

    // ==========================================================
    // Digital control pins
    arcp_debounce #(.CYC(DEB_CYC)) u_remote
    (
        .clk_sys (clk_sys),
        .resetn  (resetn),
        .ce      (ce),
        .pin     (remote_select_n_in),
        .level   (remote_n)
    );

    arcp_debounce #(.CYC(DEB_CYC)) u_rmode
    (
        .clk_sys (clk_sys),
        .resetn  (resetn),
        .ce      (ce),
        .pin     (resistance_mode_in),
        .level   (rmode)
    );

    arcp_debounce #(.CYC(DEB_CYC)) u_standby
    (
        .clk_sys (clk_sys),
        .resetn  (resetn),
        .ce      (ce),
        .pin     (output_standby_in),
        .level   (standby)
    );

    // An open pin idles high, which must read as manual control.
    assign remote  = !remote_n;
    assign range10 = ctrl[`ARCP_CTRL_RANGE10];

    // ==========================================================
    // Setpoint path
    assign port_code[0] = voltage_setpoint_in;
    assign port_code[1] = current_setpoint_in;
    assign port_code[2] = power_setpoint_in;
    assign port_code[3] = resistance_setpoint_in;

    generate
        for (genvar i = 0; i < 4; i++)
        begin : g_ch
            arcp_scale #(.W(W)) u_scale
            (
                .code_in (port_code[i]),
                .range10 (range10),
                .limit   (limit[i]),
                .value   (port_value[i])
            );

            // All channels switch source on the same remote flag, so
            // port and panel values are never mixed.
            always_ff @(posedge clk_sys or negedge resetn)
            begin
                if (!resetn)
                begin
                    applied_setpoint[i*W +: W] <= '0;
                    display_setpoint[i*W +: W] <= '0;
                end
                else if (ce)
                begin
                    applied_setpoint[i*W +: W] <=
                        remote ? port_value[i] : panel[i];
                    display_setpoint[i*W +: W] <=
                        remote ? port_value[i] : panel[i];
                end
            end
        end
    endgenerate

    // The resistance value is carried always but only takes effect
    // through this enable.
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            resistance_enable <= 1'b0;
        else if (ce)
            resistance_enable <= rmode;
    end

    // ==========================================================
    // Monitor and reference outputs
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            voltage_monitor_out <= '0;
            current_monitor_out <= '0;
            reference_out       <= '0;
        end
        else if (ce)
        begin
            // The DAC spans 10 V; the 5 V span uses its lower half.
            voltage_monitor_out <= range10 ? actual_voltage
                                           : (actual_voltage >> 1);
            current_monitor_out <= range10 ? current_monitor_src()
                                           : (actual_current >> 1);
            reference_out <= range10 ? {W{1'b1}}
                                     : {1'b0, {(W-1){1'b1}}};
        end
    end

    function automatic logic [W-1:0] current_monitor_src();
        return actual_current;
    endfunction

    // ==========================================================
    // Standby low-phase timing and acknowledge
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            sb_state        <= arcp_pkg::ARCP_SB_HIGH;
            low_count       <= '0;
            alarm_ack_pulse <= 1'b0;
        end
        else if (ce)
        begin
            alarm_ack_pulse <= 1'b0;
            case (sb_state)
                arcp_pkg::ARCP_SB_HIGH:
                begin
                    low_count <= '0;
                    if (!standby)
                        sb_state <= arcp_pkg::ARCP_SB_LOW_SHORT;
                end
                arcp_pkg::ARCP_SB_LOW_SHORT:
                begin
                    if (standby)
                        sb_state <= arcp_pkg::ARCP_SB_HIGH;
                    else if (low_count == AW'(ACK_CYC - 2))
                        sb_state <= arcp_pkg::ARCP_SB_LOW_LONG;
                    else
                        low_count <= low_count + 1'b1;
                end
                arcp_pkg::ARCP_SB_LOW_LONG:
                begin
                    if (standby)
                    begin
                        sb_state        <= arcp_pkg::ARCP_SB_HIGH;
                        alarm_ack_pulse <= remote;
                    end
                end
                default:
                    sb_state <= arcp_pkg::ARCP_SB_HIGH;
            endcase
        end
    end

    // ==========================================================
    // Alarm latch; a new alarm wins over a clear in the same cycle.
    assign any_alarm = heat_alarm | power_fail_alarm |
                       excess_voltage_alarm | excess_current_alarm;

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            latched  <= 1'b0;
            ack_seen <= 1'b0;
        end
        else if (ce)
        begin
            latched <= any_alarm |
                       (latched & !(alarm_ack_pulse | sw_ack));
            ack_seen <= alarm_ack_pulse | (ack_seen & !sw_ack);
        end
    end

    // ==========================================================
    // Output enable and status pins
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            dc_output_on             <= 1'b0;
            heat_or_supply_fail_out  <= 1'b0;
            excess_voltage_alarm_out <= 1'b0;
            const_voltage_status_out <= 1'b0;
        end
        else if (ce)
        begin
            // Standby gates the output in every control location.
            dc_output_on <= standby & !latched &
                (remote | ctrl[`ARCP_CTRL_PANELON]);
            heat_or_supply_fail_out <=
                heat_alarm | power_fail_alarm;
            excess_voltage_alarm_out <=
                excess_voltage_alarm;
            const_voltage_status_out <= (regulation_mode !=
                2'(arcp_pkg::ARCP_REG_CV));
        end
    end

    // ==========================================================
    // APB slave, one wait-free access phase
    assign rd_setup = psel & !penable;
    assign wr_en    = psel & penable & pready & pwrite & !pslverr;
    assign sw_ack   = wr_en & (paddr == `ARCP_OFF_ACK)
                    & pwdata[`ARCP_ACK_CLEAR];

    always_comb
    begin
        next_rdata = '0;
        next_err   = 1'b0;
        if (paddr == `ARCP_OFF_CTRL)
            next_rdata[1:0] = ctrl;
        else if (paddr == `ARCP_OFF_OVP)
            next_rdata[W-1:0] = ovp_threshold;
        else if (paddr == `ARCP_OFF_STATUS)
        begin
            next_rdata[`ARCP_ST_REMOTE]  = remote;
            next_rdata[`ARCP_ST_RMODE]   = rmode;
            next_rdata[`ARCP_ST_STANDBY] = standby;
            next_rdata[`ARCP_ST_DCON]    = dc_output_on;
            next_rdata[`ARCP_ST_LATCHED] = latched;
            next_rdata[`ARCP_ST_ACKSEEN] = ack_seen;
        end
        else if (paddr == `ARCP_OFF_ACK)
            next_rdata = '0;
        else if (paddr >= `ARCP_OFF_PANEL && paddr < `ARCP_OFF_OVP
                 && paddr[1:0] == 2'h0)
        begin
            if (paddr < `ARCP_OFF_LIMIT)
                next_rdata[W-1:0] = panel[2'(paddr[7:2] - 6'h01)];
            else
                next_rdata[W-1:0] = limit[2'(paddr[7:2] - 6'h05)];
        end
        else
            next_err = 1'b1;
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end
        else if (ce)
        begin
            pready  <= rd_setup;
            pslverr <= rd_setup & next_err;
            prdata  <= (rd_setup & !pwrite) ? next_rdata : 32'h00000000;
        end
    end

    // The protection threshold has no path from the port pins.
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            ctrl          <= `ARCP_RST_CTRL;
            ovp_threshold <= `ARCP_RST_OVP;
        end
        else if (ce && wr_en)
        begin
            if (paddr == `ARCP_OFF_CTRL)
                ctrl <= pwdata[1:0];
            if (paddr == `ARCP_OFF_OVP)
                ovp_threshold <= pwdata[W-1:0];
        end
    end

    generate
        for (genvar j = 0; j < 4; j++)
        begin : g_reg
            always_ff @(posedge clk_sys or negedge resetn)
            begin
                if (!resetn)
                begin
                    panel[j] <= `ARCP_RST_PANEL;
                    limit[j] <= `ARCP_RST_LIMIT;
                end
                else if (ce && wr_en)
                begin
                    if (paddr == 8'(`ARCP_OFF_PANEL + 4*j))
                        panel[j] <= pwdata[W-1:0];
                    if (paddr == 8'(`ARCP_OFF_LIMIT + 4*j))
                        limit[j] <= pwdata[W-1:0];
                end
            end
        end
    endgenerate

    // ==========================================================
    // Checks
    apply_clip_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        ce && remote |=> applied_setpoint[W-1:0] <= $past(limit[0]))
        else $error("voltage setpoint above limit");

    same_source_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        ce && !remote |=> applied_setpoint[2*W-1:W] == $past(panel[1]))
        else $error("manual current not from panel");

    display_src_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        ce |=> display_setpoint == applied_setpoint)
        else $error("display differs from applied");

    ovp_hold_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        !wr_en |=> $stable(ovp_threshold))
        else $error("threshold changed without write");

    ref_range_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        ce && !range10 |=> reference_out == {1'b0, {(W-1){1'b1}}})
        else $error("reference wrong for 5 V span");

    sb_off_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        ce && !standby |=> !dc_output_on)
        else $error("output on with standby low");

    alarm_off_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        ce && any_alarm ##1 ce |=> !dc_output_on)
        else $error("output on during alarm");

    alarm_pin_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        ce |=> excess_voltage_alarm_out == $past(excess_voltage_alarm))
        else $error("overvoltage pin wrong");

    short_pulse_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        alarm_ack_pulse && $past(ce)
        |-> $past(sb_state) == arcp_pkg::ARCP_SB_LOW_LONG)
        else $error("ack after short low phase");

    cv_pin_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        ce && regulation_mode == 2'(arcp_pkg::ARCP_REG_CV)
        |=> !const_voltage_status_out)
        else $error("regulation pin high in CV");
endmodule

// [rtl/arcp_map.svh]
// Offsets, field positions, reset values and timing counts of the
// analog remote-control port block.
// Assumes a 25 MHz system clock and 32-bit APB word registers.
`ifndef ARCP_MAP_SVH
`define ARCP_MAP_SVH

// ==========================================================
// Register byte offsets
`define ARCP_OFF_CTRL     8'h00
`define ARCP_OFF_PANEL    8'h04
`define ARCP_OFF_LIMIT    8'h14
`define ARCP_OFF_OVP      8'h24
`define ARCP_OFF_STATUS   8'h28
`define ARCP_OFF_ACK      8'h2C

// ==========================================================
// Field positions
`define ARCP_CTRL_RANGE10 0
`define ARCP_CTRL_PANELON 1
`define ARCP_ST_REMOTE    0
`define ARCP_ST_RMODE     1
`define ARCP_ST_STANDBY   2
`define ARCP_ST_DCON      3
`define ARCP_ST_LATCHED   4
`define ARCP_ST_ACKSEEN   5
`define ARCP_ACK_CLEAR    0

// ==========================================================
// Reset values
`define ARCP_RST_CTRL     2'h0
`define ARCP_RST_PANEL    14'h0000
`define ARCP_RST_LIMIT    14'h3FFF
`define ARCP_RST_OVP      14'h3FFF

// ==========================================================
// Timing
`define ARCP_CLK_KHZ      25000
`define ARCP_DEBOUNCE_US  1000
`define ARCP_ACK_LOW_MS   50
`define ARCP_DEBOUNCE_CYC ((`ARCP_DEBOUNCE_US*`ARCP_CLK_KHZ+999)/1000)
`define ARCP_ACK_LOW_CYC  (`ARCP_ACK_LOW_MS*`ARCP_CLK_KHZ)
`define ARCP_CODE_W       14

`endif

// [rtl/arcp_pkg.sv]
// Types shared by the analog remote-control port block.
// Assumes nothing beyond a SystemVerilog compiler.
package arcp_pkg;

    typedef enum logic [1:0]
    {
        ARCP_REG_CV,
        ARCP_REG_CC,
        ARCP_REG_CP,
        ARCP_REG_CR
    } arcp_reg_mode_t;

    typedef enum logic [1:0]
    {
        ARCP_SB_HIGH,
        ARCP_SB_LOW_SHORT,
        ARCP_SB_LOW_LONG
    } arcp_sb_state_t;

endpackage

// [rtl/arcp_debounce.sv]
// Two-flop synchroniser followed by a stability filter for one pin.
// Assumes the pin is asynchronous to clk_sys and idles high.
`timescale 1ns/1ps

module arcp_debounce #(
    parameter int CYC = 25000
) (
    input  wire logic clk_sys,  // system clock
    input  wire logic resetn,   // async reset, active low
    input  wire logic ce,       // clock enable
    input  wire logic pin,      // raw pin level
    output logic      level     // filtered level
);
    localparam int CW = $clog2(CYC + 1);

    logic          sync_a;
    logic          sync_b;
    logic [CW-1:0] count;

    generate
        if (CYC < 1)
        begin : g_bad
            $error("arcp_debounce: CYC must be at least 1");
        end
    endgenerate

    // ==========================================================
    // Synchroniser
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            sync_a <= 1'b1;
            sync_b <= 1'b1;
        end
        else if (ce)
        begin
            sync_a <= pin;
            sync_b <= sync_a;
        end
    end

    // ==========================================================
    // Filter: a new level is taken only after it held CYC cycles.
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            count <= '0;
            level <= 1'b1;
        end
        else if (ce)
        begin
            if (sync_b == level)
                count <= '0;
            else if (count == CW'(CYC - 1))
            begin
                count <= '0;
                level <= sync_b;
            end
            else
                count <= count + 1'b1;
        end
    end
endmodule

// [rtl/arcp_scale.sv]
// Converts one digitised setpoint input to a fraction of nominal and
// clips it to the adjustment limit.
// Assumes the converter maps 0 to 10 V onto the full code range.
`timescale 1ns/1ps

module arcp_scale #(
    parameter int W = 14
) (
    input  wire logic [W-1:0] code_in,   // converter code of the pin
    input  wire logic         range10,   // 1: 10 V span, 0: 5 V span
    input  wire logic [W-1:0] limit,     // adjustment limit
    output logic      [W-1:0] value      // scaled, clipped setpoint
);
    logic [W:0]   doubled;
    logic [W-1:0] scaled;

    // In the 5 V span half the code range is full scale, so the code
    // is doubled and saturates; this halves the usable resolution.
    always_comb
    begin
        doubled = {code_in, 1'b0};
        if (range10)
            scaled = code_in;
        else if (doubled[W])
            scaled = {W{1'b1}};
        else
            scaled = doubled[W-1:0];
        value = (scaled > limit) ? limit : scaled;
    end
endmodule

// [bench/arcp_ctrl_model.sv]
// External controller model: drives setpoint codes and control pins.
// Assumes callers start its tasks right after a clk_sys rising edge.
`timescale 1ns/1ps

module arcp_ctrl_model (
    input  wire logic        clk_sys,                // system clock
    output logic      [13:0] voltage_setpoint_in,    // pin code
    output logic      [13:0] current_setpoint_in,    // pin code
    output logic      [13:0] power_setpoint_in,      // pin code
    output logic      [13:0] resistance_setpoint_in, // pin code
    output logic             remote_select_n_in,     // low = remote
    output logic             resistance_mode_in,     // high = R mode
    output logic             output_standby_in       // low = output off
);
    // ==========================================================
    // Pin drive
    // Every setpoint pin starts at a defined level, never open.
    initial
    begin
        {resistance_setpoint_in, power_setpoint_in} = 28'h0;
        {current_setpoint_in, voltage_setpoint_in} = 28'h0;
        {remote_select_n_in, resistance_mode_in} = 2'h3;
        output_standby_in = 1'b1;
    end

    task automatic set_pins(input logic [55:0] c, input logic rn, rm);
        {resistance_setpoint_in, power_setpoint_in} <= c[55:28];
        {current_setpoint_in, voltage_setpoint_in} <= c[27:0];
        remote_select_n_in <= rn;
        resistance_mode_in <= rm;
    endtask

    // High-low-high on standby; a long low phase acknowledges under remote control.
    task automatic sb_pulse(input int low_cyc);
        output_standby_in <= 1'b0;
        repeat (low_cyc) @(posedge clk_sys);
        output_standby_in <= 1'b1;
    endtask
endmodule

// [bench/testbench.sv]
// Self-checking bench of the analog remote-control port.
// Assumes short debounce and acknowledge counts set at the instance.
`timescale 1ns/1ps

module testbench;
    logic        clk_sys = 0, resetn = 0, ce = 1, psel = 0, penable = 0;
    logic        pwrite = 0, pready, pslverr, resistance_enable, er;
    logic        dc_output_on, heat_or_supply_fail_out, alarm_ack_pulse;
    logic        excess_voltage_alarm_out, const_voltage_status_out;
    logic        heat_alarm = 0, power_fail_alarm = 0, r10, rm;
    logic        excess_voltage_alarm = 0, excess_current_alarm = 0;
    logic [7:0]  paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic [1:0]  regulation_mode = 0;
    logic [13:0] actual_voltage = 0, actual_current = 0, lim[4];
    logic [13:0] voltage_setpoint_in, current_setpoint_in, ovp_threshold;
    logic [13:0] power_setpoint_in, resistance_setpoint_in, reference_out;
    logic [13:0] voltage_monitor_out, current_monitor_out;
    logic        remote_select_n_in, resistance_mode_in, output_standby_in;
    logic [55:0] applied_setpoint, display_setpoint, c, e, m;
    int          fail_count = 0, n_tests = 0, acks = 0;

    arcp_port #(.DEB_CYC(4), .ACK_CYC(16)) u_dut (.*);
    arcp_ctrl_model u_ctl (.*);

    always #20 clk_sys = ~clk_sys;
    always @(posedge clk_sys) if (alarm_ack_pulse === 1'b1) acks <= acks + 1;

    // ==========================================================
    // Helpers
    task automatic apb(input logic w, input logic [7:0] a, input int d);
        @(posedge clk_sys);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        {rd, er} = {prdata, pslverr};
        {psel, penable} <= 2'b00;
    endtask

    task automatic chk(input string n, input logic [55:0] x, g);
        n_tests++;
        if (g !== x)
        begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", n, x, g);
        end
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    function automatic logic [55:0] exp_vec(logic [55:0] v, logic r);
        logic [13:0] s;
        for (int k = 0; k < 4; k++)
        begin
            s = v[14*k +: 14];
            if (!r)
                s = s[13] ? 14'h3FFF : {s[12:0], 1'b0};
            exp_vec[14*k +: 14] = (s > lim[k]) ? lim[k] : s;
        end
    endfunction

    task give_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial
    begin
        wt(6000);
        fail_count++;
        give_verdict;
    end

    // ==========================================================
    // Scenarios
    initial
    begin
        void'($urandom(58875));
        wt(20);
        resetn <= 1'b1;
        wt(12); // Status pins are not judged before start-up ends.
        apb(0, 8'h14, 0);
        chk("limit_reset", 56'h3FFF, rd);
        apb(0, 8'h30, 0);
        chk("unmapped_err", 1, er);
        apb(1, 8'h04, 32'h123);
        apb(1, 8'h24, 32'hABC);
        wt(3);
        chk("manual_v", 14'h123, applied_setpoint[13:0]);
        chk("ovp", 14'hABC, ovp_threshold);
        for (int i = 0; i < 6; i++)
        begin
            {rm, r10} = 2'(i);
            apb(1, 8'h00, {31'h0, r10});
            for (int k = 0; k < 4; k++)
            begin
                lim[k] = 14'($urandom);
                apb(1, 8'(8'h14 + 4*k), {18'h0, lim[k]});
            end
            c = (i == 4) ? '1 : (i == 5) ? '0 : 56'({$urandom, $urandom});
            {actual_voltage, actual_current} <= 28'($urandom);
            u_ctl.set_pins(c, 1'b0, rm);
            wt(12);
            m = rm ? '1 : 56'h3FF_FFFF_FFFF;
            e = exp_vec(c, r10) & m;
            chk("applied", e, applied_setpoint & m);
            chk("display", e, display_setpoint & m);
            chk("r_enable", rm, resistance_enable);
            chk("reference", r10 ? 14'h3FFF : 14'h1FFF,
                reference_out);
            chk("monitors", r10 ? {actual_voltage, actual_current} :
                {actual_voltage >> 1, actual_current >> 1},
                {voltage_monitor_out,
                current_monitor_out});
        end
        for (int k = 0; k < 4; k++)
        begin
            regulation_mode <= 2'(k);
            wt(3);
            chk("cv_status", k != 0, const_voltage_status_out);
        end
        // Clock enable low must freeze the status pin at its old level.
        ce <= 1'b0;
        regulation_mode <= 2'h0;
        wt(5);
        chk("ce_frozen", 1, const_voltage_status_out);
        ce <= 1'b1;
        wt(3);
        chk("ce_running", 0, const_voltage_status_out);
        u_ctl.sb_pulse(2);
        wt(12);
        chk("glitch_kept_on", 1, dc_output_on);
        for (int k = 0; k < 4; k++)
        begin
            {excess_current_alarm, excess_voltage_alarm, power_fail_alarm,
             heat_alarm} <= 4'(1 << k);
            wt(3);
            chk("alarm_pins", {k < 2, k == 2, 1'b0},
                {heat_or_supply_fail_out, excess_voltage_alarm_out,
                dc_output_on});
            {excess_current_alarm, excess_voltage_alarm} <= 2'b00;
            {power_fail_alarm, heat_alarm} <= 2'b00;
            u_ctl.sb_pulse(8);
            wt(12);
            chk("short_no_ack", {k, 1'b0}, {acks, dc_output_on});
            u_ctl.sb_pulse(30);
            wt(12);
            chk("ack_on", {k + 1, 1'b1}, {acks, dc_output_on});
        end
        apb(0, 8'h28, 0);
        chk("ack_seen", 1, rd[5]);
        apb(1, 8'h2C, 1);
        apb(0, 8'h28, 0);
        chk("ack_cleared", 0, rd[5]);
        u_ctl.set_pins(c, 1'b1, 1'b1);
        apb(1, 8'h00, 32'h3);
        wt(12);
        chk("manual_on", 1, dc_output_on);
        fork
            u_ctl.sb_pulse(20);
            wt(14);
        join_any
        chk("standby_off", 0, dc_output_on);
        wt(20);
        give_verdict;
    end
endmodule
